// *** i2crb_pkg.sv ***
// Purpose: shared constants and types of the serial register block port
// Assumes: mclk at 40 MHz, bus clock far slower (sampled, not used as clock)
// Notes:   slave addresses held in 8-bit write form; bit 0 is the R/W bit
`default_nettype none
package i2crb_pkg;

    // slave address forms, 8-bit write form
    localparam logic [7:0] ADDR_DEFAULT_8B = 8'hD4;
    localparam logic [7:0] ADDR_ALT_8B     = 8'hD0;

    // byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] FIRST_BIT = 4'h1;
    localparam logic [7:0] EMPTY_BYTE = 8'h00;

    // register pointer width (two address bytes)
    localparam int PTR_W = 16;

    // one staged write: target register and its byte
    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [7:0]       data;
    } i2crb_stg_t;

    // transfer phases
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_AHI   = 3'h2,
        ST_ALO   = 3'h3,
        ST_WDATA = 3'h4,
        ST_ACK   = 3'h5,
        ST_RDATA = 3'h6,
        ST_RACK  = 3'h7
    } i2crb_state_t;

endpackage : i2crb_pkg
`default_nettype wire

// *** i2crb_fifo.sv ***
// Purpose: prefetch buffer between the register file and the serial sender
// Assumes: DEPTH is a power of two
// Notes:   flush empties the buffer in one cycle and wins over push and pop
`timescale 1ns/10ps
`default_nettype none
module i2crb_fifo
    import i2crb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } i2crb_fifo_st_t;

    i2crb_fifo_st_t r_reg;
    i2crb_fifo_st_t r_next;
    logic           push;
    logic           pop;

    assign in_ready  = (r_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r_reg.cnt != '0);
    assign out_data  = r_reg.mem[r_reg.rp];

    always_comb begin
        r_next = r_reg;
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        if (flush) begin
            r_next.wp  = '0;
            r_next.rp  = '0;
            r_next.cnt = '0;
        end else begin
            if (push) begin
                r_next.mem[r_reg.wp] = in_data;
                r_next.wp = r_reg.wp + 1'b1;
            end
            if (pop) begin
                r_next.rp = r_reg.rp + 1'b1;
            end
            if (push && !pop) begin
                r_next.cnt = r_reg.cnt + 1'b1;
            end else if (pop && !push) begin
                r_next.cnt = r_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    a_fifo_bounds : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE2]
        r_reg.cnt <= (AW+1)'(DEPTH))
        else $error("buffer count beyond depth");

endmodule : i2crb_fifo
`default_nettype wire

// *** i2crb_port.sv ***
// Purpose: serial slave port that writes and reads a bank of config registers
// Assumes: bus pins sampled by mclk; no software-reachable registers
// Notes:   writes are staged and land together at the end of the transfer
//
// Behaviour
// [RULE1] answer at one of two slave addresses, the 0xD0 or 0xD4 form
// [RULE2] accept block writes and block reads of any length; data bytes after the first STG_DEPTH of a write are refused
// [RULE3] two address bytes set the register where a transfer starts
// [RULE4] each further data byte targets the next higher register
// [RULE5] data bytes travel most significant bit first, both directions
// [RULE6] the master may end a transfer after any complete byte
// [RULE7] written bytes stay staged; working registers unchanged until stop
// [RULE8] on stop all staged bytes are committed in one update; bytes staged for registers beyond the bank are dropped, not committed
// [RULE9] master keeps the bus clock between 10 kHz and 400 kHz; the bench master runs it at 5 MHz (200 ns period)
// [RULE10] address is the 0xD4 form by default, 0xD0 when select is set
// [RULE11] foreign-address transfers are ignored: no acknowledge, no drive
// [RULE12] a stop inside a byte drops that partial byte
`timescale 1ns/10ps
`default_nettype none
module i2crb_port
    import i2crb_pkg::*;
#(
    parameter int REG_COUNT  = 16,
    parameter int STG_DEPTH  = 16,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    // serial bus pins
    input  wire logic                   scl_in,
    input  wire logic                   serial_data_line_in,
    output var  logic                   serial_data_line_out,
    output var  logic                   serial_data_line_oe,
    // address select strap
    input  wire logic                   addr_sel,
    // working registers
    output var  logic [REG_COUNT*8-1:0] reg_image,
    output var  logic                   commit_pulse
);
    localparam int RIW = $clog2(REG_COUNT);
    localparam int SCW = $clog2(STG_DEPTH) + 1;

    typedef struct packed {
        logic                          scl_s1;
        logic                          scl_s2;
        logic                          scl_d;
        logic                          sda_s1;
        logic                          sda_s2;
        logic                          sda_d;
        logic                          sel_s1;
        logic                          sel_s2;
        i2crb_state_t                  st;
        i2crb_state_t                  nxt;
        logic [3:0]                    cnt;
        logic [7:0]                    sh;
        logic [7:0]                    ahi;
        logic [7:0]                    tx;
        logic                          mnack;
        logic                          sda_oe;
        logic                          sda_low;
        logic [PTR_W-1:0]              ptr;
        logic [PTR_W-1:0]              rd_ptr;
        logic                          pf_on;
        logic [SCW-1:0]                stg_cnt;
        logic [STG_DEPTH-1:0][23:0]    stg;
        logic [REG_COUNT-1:0][7:0]     regs;
        logic                          commit;
    } i2crb_st_t;

    i2crb_st_t  r;
    i2crb_st_t  n;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [6:0] own_addr;
    logic       fifo_flush;
    logic       pf_ready;
    logic [7:0] pf_data;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       load_tx;
    i2crb_stg_t ent;

    ////////////////////////////////////////////////////////////////////////
    // bus events, taken only from the second and third sampling stages
    assign scl_rise  = r.scl_s2 && !r.scl_d;
    assign scl_fall  = !r.scl_s2 && r.scl_d;
    assign start_det = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
    assign stop_det  = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;
    assign own_addr  = r.sel_s2 ? ADDR_ALT_8B[7:1] : ADDR_DEFAULT_8B[7:1]; // see [RULE10]

    // prefetch reads ahead of the sender; beyond the bank reads as zero
    assign pf_data = (r.rd_ptr < PTR_W'(REG_COUNT)) ? r.regs[r.rd_ptr[RIW-1:0]]
                                                      : EMPTY_BYTE;

    i2crb_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .flush     (fifo_flush),
        .in_valid  (r.pf_on),
        .in_ready  (pf_ready),
        .in_data   (pf_data),
        .out_valid (tx_valid),
        .out_ready (load_tx),
        .out_data  (tx_data)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n            = r;
        ent          = '0;
        fifo_flush   = 1'b0;
        load_tx      = 1'b0;
        n.commit     = 1'b0;
        n.sda_low    = 1'b0;
        n.scl_s1     = scl_in;
        n.scl_s2     = r.scl_s1;
        n.scl_d      = r.scl_s2;
        n.sda_s1     = serial_data_line_in;
        n.sda_s2     = r.sda_s1;
        n.sda_d      = r.sda_s2;
        n.sel_s1     = addr_sel;
        n.sel_s2     = r.sel_s1;
        if (r.pf_on && pf_ready) begin
            n.rd_ptr = r.rd_ptr + 1'b1;
        end
        if (stop_det) begin
            // partial byte in the shifter is simply never staged
            for (int i = 0; i < STG_DEPTH; i++) begin
                ent = r.stg[i];
                if (i < int'(r.stg_cnt) && ent.addr < PTR_W'(REG_COUNT)) begin
                    n.regs[ent.addr[RIW-1:0]] = ent.data; // see [RULE8]
                end
            end
            n.commit  = (r.stg_cnt != '0); // see [RULE12]
            n.stg_cnt = '0;
            n.st      = ST_IDLE; // see [RULE6]
            n.sda_oe  = 1'b0;
            n.pf_on   = 1'b0;
        end else if (start_det) begin
            // staged bytes survive a repeated start; only stop commits
            n.st     = ST_ADDR;
            n.cnt    = '0;
            n.sda_oe = 1'b0;
            n.pf_on  = 1'b0;
        end else begin
            if (scl_rise) begin
                if (r.st == ST_RACK) begin
                    n.mnack = r.sda_s2;
                end else if (r.st inside {ST_ADDR, ST_AHI, ST_ALO, ST_WDATA}
                             && r.cnt < BYTE_BITS) begin
                    n.sh  = {r.sh[6:0], r.sda_s2}; // see [RULE5]
                    n.cnt = r.cnt + 1'b1;
                end
            end
            if (scl_fall) begin
                unique case (r.st)
                    ST_IDLE: begin
                    end
                    ST_ADDR: begin
                        if (r.cnt == BYTE_BITS) begin
                            if (r.sh[7:1] == own_addr) begin
                                n.sda_oe = 1'b1; // see [RULE1]
                                n.st     = ST_ACK;
                                n.nxt    = r.sh[0] ? ST_RDATA : ST_AHI;
                                if (r.sh[0]) begin
                                    fifo_flush = 1'b1;
                                    n.rd_ptr   = r.ptr; // see [RULE3]
                                    n.pf_on    = 1'b1;
                                end
                            end else begin
                                n.st = ST_IDLE; // see [RULE11]
                            end
                        end
                    end
                    ST_AHI: begin
                        if (r.cnt == BYTE_BITS) begin
                            n.ahi    = r.sh;
                            n.sda_oe = 1'b1;
                            n.st     = ST_ACK;
                            n.nxt    = ST_ALO;
                        end
                    end
                    ST_ALO: begin
                        if (r.cnt == BYTE_BITS) begin
                            n.ptr    = {r.ahi, r.sh}; // see [RULE3]
                            n.sda_oe = 1'b1;
                            n.st     = ST_ACK;
                            n.nxt    = ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (r.cnt == BYTE_BITS) begin
                            if (r.stg_cnt < SCW'(STG_DEPTH)) begin
                                ent.addr = r.ptr;
                                ent.data = r.sh;
                                n.stg[r.stg_cnt[SCW-2:0]] = ent; // see [RULE7]
                                n.stg_cnt = r.stg_cnt + 1'b1;
                                n.ptr     = r.ptr + 1'b1; // see [RULE4]
                                n.sda_oe  = 1'b1;
                                n.st      = ST_ACK;
                                n.nxt     = ST_WDATA; // see [RULE2]
                            end else begin
                                // staging full: refuse, wait for stop
                                n.st = ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        n.sda_oe = 1'b0;
                        n.cnt    = '0;
                        n.sh     = '0;
                        if (r.nxt == ST_RDATA) begin
                            load_tx = 1'b1;
                        end else begin
                            n.st = r.nxt;
                        end
                    end
                    ST_RDATA: begin
                        if (r.cnt == BYTE_BITS) begin
                            n.sda_oe = 1'b0;
                            n.st     = ST_RACK;
                        end else begin
                            n.tx     = {r.tx[6:0], 1'b0};
                            n.sda_oe = !r.tx[6]; // see [RULE5]
                            n.cnt    = r.cnt + 1'b1;
                        end
                    end
                    ST_RACK: begin
                        if (!r.mnack) begin
                            load_tx = 1'b1; // see [RULE2]
                        end else begin
                            n.st = ST_IDLE; // see [RULE6]
                        end
                    end
                endcase
            end
        end
        if (load_tx) begin
            n.tx     = tx_valid ? tx_data : EMPTY_BYTE;
            n.sda_oe = !n.tx[7]; // see [RULE5]
            n.cnt    = FIRST_BIT;
            n.ptr    = r.ptr + 1'b1; // see [RULE4]
            n.st     = ST_RDATA;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign serial_data_line_out = r.sda_low;
    assign serial_data_line_oe  = r.sda_oe;
    assign reg_image            = r.regs;
    assign commit_pulse         = r.commit;

    ////////////////////////////////////////////////////////////////////////
    a_regs_held_till_stop : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE7]
        !$stable(r.regs) |-> r.commit && $past(stop_det))
        else $error("working registers changed outside a commit");

    a_commit_on_stop : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE8]
        stop_det && r.stg_cnt != '0 |=> r.commit && r.stg_cnt == '0)
        else $error("staged bytes not committed at stop");

    a_partial_dropped : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE12]
        stop_det && r.st == ST_WDATA && r.cnt != '0 |=> r.commit == ($past(r.stg_cnt) != '0))
        else $error("partial byte changed the commit");

    a_stop_ends_xfer : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE6]
        stop_det |=> r.st == ST_IDLE && !r.sda_oe)
        else $error("transfer not ended by stop");

    a_foreign_silent : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE11]
        r.st == ST_ADDR && scl_fall && r.cnt == BYTE_BITS && r.sh[7:1] != own_addr
        |=> r.st == ST_IDLE && !r.sda_oe)
        else $error("foreign address was answered");

    a_addr_select : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE10]
        r.st == ST_ADDR && scl_fall && r.cnt == BYTE_BITS && !start_det && !stop_det
        && r.sh[7:1] == (r.sel_s2 ? ADDR_ALT_8B[7:1] : ADDR_DEFAULT_8B[7:1])
        |=> r.st == ST_ACK && r.sda_oe)
        else $error("own address not acknowledged");

    a_idle_no_drive : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE1]
        r.st == ST_IDLE |-> !r.sda_oe)
        else $error("data line driven while idle");

    a_ptr_load : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE3]
        r.st == ST_ALO && scl_fall && r.cnt == BYTE_BITS && !start_det && !stop_det
        |=> r.ptr == {$past(r.ahi), $past(r.sh)})
        else $error("start register not taken from address bytes");

    a_ptr_advance : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE4]
        load_tx |=> r.ptr == $past(r.ptr) + 1'b1 && r.st == ST_RDATA)
        else $error("register pointer did not advance");

    a_msb_first : assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE5]
        r.st == ST_RDATA |-> r.sda_oe == !r.tx[7])
        else $error("sent bit is not the top bit of the shifter");

endmodule : i2crb_port
`default_nettype wire

// *** i2crb_master.sv ***
// Purpose: behavioural bus master for the serial register port
// Assumes: bus clock period of 8 mclk cycles; released wire pulls up
// Notes:   data moves mid-low; the master samples at the end of high
`timescale 1ns/10ps
`default_nettype none
module i2crb_master (
    // clock
    input  wire logic mclk,
    // bus
    output var  logic scl,
    output var  logic sda_pull,
    input  wire logic sda_wire
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // late sample leaves room for the device's sync delay
    // 200 ns bus period is a bench speed-up past the allowed bus rate
    task automatic clk_bit(input logic b, output logic got);
        sda_pull = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
        got = sda_wire;
        scl = 1'b0;
        tick(2);
    endtask : clk_bit

    task automatic start();
        if (!scl) begin
            sda_pull = 1'b0;
            tick(2);
            scl = 1'b1;
            tick(4);
        end
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask : start

    task automatic stop();
        sda_pull = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(4);
    endtask : stop

    task automatic send(input logic [7:0] d, input int nbits, output logic ack);
        logic g;
        for (int i = 7; i > 7 - nbits; i--) clk_bit(d[i], g);
        ack = 1'b0;
        if (nbits == 8) begin
            clk_bit(1'b1, g);
            ack = ~g;
        end
    endtask : send

    task automatic recv(input logic more, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, g);
            d[i] = g;
        end
        clk_bit(~more, g);
    endtask : recv
endmodule : i2crb_master
`default_nettype wire

// *** tb_i2crb_port.sv ***
// Purpose: self-checking bench of the serial register port and its buffer
// Assumes: pull-up on the data wire; bus clock 200 ns
// Notes:   register model kept in plain ints, updated only at stop
`timescale 1ns/10ps
`default_nettype none
module tb_i2crb_port;
    import i2crb_pkg::*;
    localparam int NREG = 16;
    localparam int STG  = 16;
    logic              mclk, sys_rst, addr_sel, scl, sda_pull, sda_wire, dev_out, dev_oe;
    logic              commit_pulse, oe_seen;
    logic [NREG*8-1:0] reg_image;
    int                fail_count, total_checks, mreg[NREG];
    int                cycles = 0;
    int                commits = 0;
    integer            seed;

    assign sda_wire = ~(sda_pull | (dev_oe & ~dev_out));

    i2crb_port #(.REG_COUNT(NREG), .STG_DEPTH(STG), .FIFO_DEPTH(16)) u_i2crb_port (
        .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .serial_data_line_in(sda_wire),
        .serial_data_line_out(dev_out), .serial_data_line_oe(dev_oe),
        .addr_sel(addr_sel), .reg_image(reg_image), .commit_pulse(commit_pulse));
    i2crb_master u_i2crb_master (.mclk(mclk), .scl(scl), .sda_pull(sda_pull),
        .sda_wire(sda_wire));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (dev_oe === 1'b1) oe_seen <= 1'b1;
        if (commit_pulse === 1'b1) commits <= commits + 1;
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : chk_bit

    task automatic chk_regs();
        for (int k = 0; k < NREG; k++) chk_byte("reg", mreg[k][7:0], reg_image[8*k +: 8]);
    endtask : chk_regs

    task automatic write_txn(input logic [7:0] dev, input logic [15:0] ptr, input int n,
                             input logic cut);
        logic       ack, m;
        logic [7:0] d;
        logic [7:0] stg[$];
        int         c0;
        m = (dev[7:1] == (addr_sel ? ADDR_ALT_8B[7:1] : ADDR_DEFAULT_8B[7:1]));
        oe_seen = 1'b0;
        c0 = commits;
        u_i2crb_master.start();
        u_i2crb_master.send(dev, 8, ack);
        chk_bit("addr ack", m, ack);
        u_i2crb_master.send(ptr[15:8], 8, ack);
        u_i2crb_master.send(ptr[7:0], 8, ack);
        // staging holds STG bytes; the one after is refused
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            u_i2crb_master.send(d, 8, ack);
            chk_bit("data ack", m && i < STG, ack);
            if (i < STG) stg.push_back(d);
        end
        chk_regs();
        if (cut) u_i2crb_master.send(8'h5A, 4, ack);
        u_i2crb_master.stop();
        repeat (6) @(negedge mclk);
        if (!m) chk_bit("oe foreign", 1'b0, oe_seen);
        foreach (stg[i]) begin
            if (m && int'(ptr) + i < NREG) mreg[int'(ptr) + i] = stg[i];
        end
        chk_byte("commits", (m && n > 0) ? 8'h01 : 8'h00, 8'(commits - c0));
        chk_regs();
    endtask : write_txn

    task automatic read_txn(input logic [15:0] ptr, input int n);
        logic       ack;
        logic [7:0] d, dev, e;
        dev = addr_sel ? ADDR_ALT_8B : ADDR_DEFAULT_8B;
        u_i2crb_master.start();
        u_i2crb_master.send(dev, 8, ack);
        u_i2crb_master.send(ptr[15:8], 8, ack);
        u_i2crb_master.send(ptr[7:0], 8, ack);
        u_i2crb_master.start();
        u_i2crb_master.send(dev | 8'h01, 8, ack);
        chk_bit("read ack", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            e = (int'(ptr) + i < NREG) ? 8'(mreg[int'(ptr) + i]) : 8'h00;
            u_i2crb_master.recv(i < n - 1, d);
            chk_byte("read", e, d);
        end
        u_i2crb_master.stop();
        repeat (4) @(negedge mclk);
    endtask : read_txn

    // read longer than the prefetch buffer, so it must refill while the bytes go out
    task automatic fifo_test();
        int c0;
        c0 = commits;
        read_txn(16'h0000, 20);
        chk_bit("oe after read", 1'b0, dev_oe);
        chk_byte("read commits", 8'h00, 8'(commits - c0));
    endtask : fifo_test

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h96f4;
        fail_count = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        addr_sel = 1'b0;
        oe_seen = 1'b0;
        foreach (mreg[k]) mreg[k] = 0;
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (6) @(negedge mclk);
        chk_regs();
        chk_bit("oe idle", 1'b0, dev_oe);
        write_txn(ADDR_DEFAULT_8B, 16'h000E, 3, 1'b0);
        write_txn(ADDR_DEFAULT_8B, 16'h0002, 4, 1'b1);
        write_txn(ADDR_ALT_8B, 16'h0000, 2, 1'b0);
        addr_sel = 1'b1;
        repeat (6) @(negedge mclk);
        write_txn(ADDR_DEFAULT_8B, 16'h0000, 1, 1'b0);
        write_txn(ADDR_ALT_8B, 16'h0000, 5, 1'b0);
        read_txn(16'h000D, 5);
        read_txn(16'h0001, 1);
        write_txn(ADDR_ALT_8B, 16'h0000, STG + 1, 1'b0);
        fifo_test();
        test_done();
    end
endmodule : tb_i2crb_port
`default_nettype wire
